//--- verilog/accsr_consts.svh
// register offsets, field positions, reset values and timing counts of the status/config slice
`ifndef ACCSR_CONSTS_SVH
`define ACCSR_CONSTS_SVH
`define ACCSR_ADDR_ORIENT    8'h0c
`define ACCSR_ADDR_FIFOST    8'h0e
`define ACCSR_ADDR_RANGE     8'h0f
`define ACCSR_ADDR_BW        8'h10
`define ACCSR_ADDR_PWR       8'h11
`define ACCSR_ADDR_FIFOCFG1  8'h3e
`define ACCSR_RANGE_RST      4'h3
`define ACCSR_BW_RST         5'h0f
`define ACCSR_SLEEP_RST      4'h0
`define ACCSR_RANGE_2G       4'h3
`define ACCSR_RANGE_4G       4'h5
`define ACCSR_RANGE_8G       4'h8
`define ACCSR_RANGE_16G      4'hc
`define ACCSR_FLAT_BIT       7
`define ACCSR_ORIENT_LSB     4
`define ACCSR_HSIGN_BIT      3
`define ACCSR_OVR_BIT        7
`define ACCSR_SUSP_BIT       7
`define ACCSR_LPEN_BIT       6
`define ACCSR_DEEP_BIT       5
`define ACCSR_SLEEP_LSB      1
`define ACCSR_FIFO_DEPTH     7'd32
`define ACCSR_LATCH_NONE     4'h0
`define ACCSR_LATCH_NONE2    4'h8
`define ACCSR_LATCH_PERM     4'h7
`define ACCSR_LATCH_PERM2    4'hf
`define ACCSR_TEMP_LATCH_MS  250
`define ACCSR_CLK_KHZ        25000
`define ACCSR_TEMP_LATCH_CYC (`ACCSR_TEMP_LATCH_MS * `ACCSR_CLK_KHZ)
`define ACCSR_SLEEP_US_MIN   20'd500
`define ACCSR_SLEEP_US_6     20'd1000
`define ACCSR_SLEEP_US_7     20'd2000
`define ACCSR_SLEEP_US_8     20'd4000
`define ACCSR_SLEEP_US_9     20'd6000
`define ACCSR_SLEEP_US_10    20'd10000
`define ACCSR_SLEEP_US_11    20'd25000
`define ACCSR_SLEEP_US_12    20'd50000
`define ACCSR_SLEEP_US_13    20'd100000
`define ACCSR_SLEEP_US_14    20'd500000
`define ACCSR_SLEEP_US_15    20'd1000000
`endif

//--- verilog/accsr_pkg.sv
// types shared by the status/config register slice
`default_nettype none
package accsr_pkg;
  typedef enum logic [3:0] {
    ACCSR_PWR_NORMAL = 4'b0001,
    ACCSR_PWR_DEEP   = 4'b0010,
    ACCSR_PWR_LOW    = 4'b0100,
    ACCSR_PWR_SUSP   = 4'b1000
  } accsr_pwr_t;

  typedef enum logic [2:0] {
    ACCSR_LATCH_K_NONE = 3'b001,
    ACCSR_LATCH_K_TEMP = 3'b010,
    ACCSR_LATCH_K_PERM = 3'b100
  } accsr_latch_t;

  typedef struct packed {
    logic [2:0]  orient;
    logic        flat;
    logic        highSign;
    logic [2:0]  highAxis;
    logic        overrun;
    logic [6:0]  count;
    logic [3:0]  rangeF;
    logic [4:0]  bwF;
    logic [3:0]  sleepF;
    accsr_pwr_t  pwr;
    logic [22:0] timer;
    logic [7:0]  rdData;
    logic        rdValid;
    logic        cfgStrobe;
    logic [2:0]  bwIdx;
    logic [19:0] sleepUs;
  } accsr_state_t;
endpackage
`default_nettype wire

//--- verilog/accsr_decode.sv
// decodes the filter cutoff and sleep duration fields into index and microseconds
`timescale 1ns/100ps
`include "accsr_consts.svh"
`default_nettype none
module accsr_decode (
  // fields
  input  wire logic [4:0]  filterCutoffField,
  input  wire logic [3:0]  sleepField,
  // decoded
  output logic      [2:0]  cutoffIdx,
  output logic      [19:0] sleepUs
);
  // index 0 is 7.81 Hz, each step doubles, 7 is 1000 Hz
  always_comb begin
    if (filterCutoffField[4]) begin
      cutoffIdx = 3'h7;
    end else if (!filterCutoffField[3]) begin
      cutoffIdx = 3'h0;
    end else begin
      cutoffIdx = filterCutoffField[2:0];
    end
  end

  always_comb begin
    unique case (sleepField)
      4'h6:    sleepUs = `ACCSR_SLEEP_US_6;
      4'h7:    sleepUs = `ACCSR_SLEEP_US_7;
      4'h8:    sleepUs = `ACCSR_SLEEP_US_8;
      4'h9:    sleepUs = `ACCSR_SLEEP_US_9;
      4'ha:    sleepUs = `ACCSR_SLEEP_US_10;
      4'hb:    sleepUs = `ACCSR_SLEEP_US_11;
      4'hc:    sleepUs = `ACCSR_SLEEP_US_12;
      4'hd:    sleepUs = `ACCSR_SLEEP_US_13;
      4'he:    sleepUs = `ACCSR_SLEEP_US_14;
      4'hf:    sleepUs = `ACCSR_SLEEP_US_15;
      default: sleepUs = `ACCSR_SLEEP_US_MIN;
    endcase
  end
endmodule
`default_nettype wire

//--- verilog/accsr_regs.sv
// orientation/high-g status, queue fill status and range/cutoff/power configuration registers
`timescale 1ns/100ps
`include "accsr_consts.svh"
`default_nettype none
module accsr_regs #(
  parameter int TEMP_LATCH_CYCLES = `ACCSR_TEMP_LATCH_CYC
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // serial register port, already deserialised
  input  wire logic [7:0]             regAddr,
  input  wire logic                   regWrite,
  input  wire logic [7:0]             regWrData,
  input  wire logic                   regRead,
  output logic      [7:0]             regRdData,
  output logic                        regRdValid,
  // interrupt engine side
  input  wire logic [3:0]             latchPolicy,
  input  wire logic                   latchClear,
  input  wire logic                   flatEn,
  input  wire logic                   flatNow,
  input  wire logic [2:0]             orientNow,
  input  wire logic                   orientBlock,
  input  wire logic [2:0]             highEn,
  input  wire logic                   highFire,
  input  wire logic                   highSignNow,
  input  wire logic [2:0]             highAxisNow,
  // queue storage side
  input  wire logic                   framePush,
  input  wire logic                   framePop,
  output logic                        fifoCfgWrite,
  // configuration to the sensing path
  output logic      [3:0]             rangeField,
  output logic      [2:0]             cutoffIdx,
  output logic      [19:0]            sleepPhaseUs,
  output var accsr_pkg::accsr_pwr_t   powerMode
);
  accsr_pkg::accsr_state_t s_reg;
  accsr_pkg::accsr_state_t s_next;
  logic [2:0]  decIdx;
  logic [19:0] decSleep;
  logic        highTrig;
  logic        flatTrig;
  logic        cfgWr;
  logic        ovrSet;

  function automatic accsr_pkg::accsr_latch_t latchKind(input logic [3:0] p);
    if (p == `ACCSR_LATCH_NONE || p == `ACCSR_LATCH_NONE2) begin
      return accsr_pkg::ACCSR_LATCH_K_NONE;
    end else if (p == `ACCSR_LATCH_PERM || p == `ACCSR_LATCH_PERM2) begin
      return accsr_pkg::ACCSR_LATCH_K_PERM;
    end
    return accsr_pkg::ACCSR_LATCH_K_TEMP;
  endfunction

  function automatic logic legalRange(input logic [3:0] r);
    return r == `ACCSR_RANGE_2G || r == `ACCSR_RANGE_4G || r == `ACCSR_RANGE_8G || r == `ACCSR_RANGE_16G;
  endfunction

  function automatic logic [2:0] pwrBits(input accsr_pkg::accsr_pwr_t m);
    unique case (m)
      accsr_pkg::ACCSR_PWR_DEEP: return 3'h1;
      accsr_pkg::ACCSR_PWR_LOW:  return 3'h2;
      accsr_pkg::ACCSR_PWR_SUSP: return 3'h4;
      default:                   return 3'h0;
    endcase
  endfunction

  accsr_decode u_decode (
    .filterCutoffField (s_reg.bwF),
    .sleepField        (s_reg.sleepF),
    .cutoffIdx         (decIdx),
    .sleepUs           (decSleep)
  );

  assign highTrig = highFire && |(highAxisNow & highEn);
  assign flatTrig = flatEn && flatNow;
  assign cfgWr    = regWrite && regAddr == `ACCSR_ADDR_FIFOCFG1;
  assign ovrSet   = framePush && !framePop && s_reg.count == `ACCSR_FIFO_DEPTH;

  always_comb begin
    logic                  clrLatched;
    logic [2:0]            bits;
    accsr_pkg::accsr_pwr_t newPwr;
    logic                  legalPwr;
    clrLatched = 1'b0;
    bits       = 3'h0;
    newPwr     = s_reg.pwr;
    legalPwr   = 1'b0;
    s_next           = s_reg;
    s_next.rdValid   = 1'b0;
    s_next.cfgStrobe = cfgWr;
    s_next.bwIdx     = decIdx;
    s_next.sleepUs   = decSleep;

    // orientation is never latched, only frozen by the blocking condition
    if (!orientBlock) begin
      s_next.orient = orientNow;
    end

    // one shared hold timer: any new trigger restarts the temporary window
    if (latchKind(latchPolicy) == accsr_pkg::ACCSR_LATCH_K_TEMP) begin
      if (highTrig || flatTrig) begin
        s_next.timer = 23'(TEMP_LATCH_CYCLES);
      end else if (s_reg.timer != 23'h0) begin
        s_next.timer = s_reg.timer - 23'h1;
      end
    end else begin
      s_next.timer = 23'h0;
    end
    unique case (latchKind(latchPolicy))
      accsr_pkg::ACCSR_LATCH_K_NONE: clrLatched = 1'b1;
      accsr_pkg::ACCSR_LATCH_K_TEMP: clrLatched = latchClear || s_reg.timer == 23'h0;
      accsr_pkg::ACCSR_LATCH_K_PERM: clrLatched = latchClear;
    endcase

    // a trigger in the clearing cycle wins
    if (flatTrig) begin
      s_next.flat = 1'b1;
    end else if (clrLatched) begin
      s_next.flat = 1'b0;
    end
    if (highTrig) begin
      s_next.highSign = highSignNow;
      s_next.highAxis = highAxisNow & highEn;
    end else if (clrLatched) begin
      s_next.highSign = 1'b0;
      s_next.highAxis = 3'h0;
    end

    // fill count: a config write empties it, a push in the same cycle still counts unless the queue was full
    if (cfgWr) begin
      s_next.count = 7'h0;
    end
    if (framePush && !framePop && !ovrSet) begin
      s_next.count = s_next.count + 7'h1;
    end else if (framePop && !framePush && s_next.count != 7'h0) begin
      s_next.count = s_next.count - 7'h1;
    end
    if (ovrSet) begin
      s_next.overrun = 1'b1;
    end else if (cfgWr) begin
      s_next.overrun = 1'b0;
    end

    // configuration writes; status offsets fall through untouched
    if (regWrite) begin
      unique case (regAddr)
        `ACCSR_ADDR_RANGE: begin
          // reserved range codes are refused so the sensing path never sees them
          if (legalRange(regWrData[3:0]) && s_reg.pwr != accsr_pkg::ACCSR_PWR_DEEP) begin
            s_next.rangeF = regWrData[3:0];
          end
        end
        `ACCSR_ADDR_BW: begin
          if (s_reg.pwr != accsr_pkg::ACCSR_PWR_DEEP) begin
            s_next.bwF = regWrData[4:0];
          end
        end
        `ACCSR_ADDR_PWR: begin
          bits = {regWrData[`ACCSR_SUSP_BIT], regWrData[`ACCSR_LPEN_BIT], regWrData[`ACCSR_DEEP_BIT]};
          legalPwr = 1'b1;
          unique case (bits)
            3'h0:    newPwr = accsr_pkg::ACCSR_PWR_NORMAL;
            3'h1:    newPwr = accsr_pkg::ACCSR_PWR_DEEP;
            3'h2:    newPwr = accsr_pkg::ACCSR_PWR_LOW;
            3'h4:    newPwr = accsr_pkg::ACCSR_PWR_SUSP;
            default: legalPwr = 1'b0;
          endcase
          if (legalPwr) begin
            s_next.pwr    = newPwr;
            s_next.sleepF = regWrData[`ACCSR_SLEEP_LSB +: 4];
            // deep suspend drops the configuration back to defaults
            if (newPwr == accsr_pkg::ACCSR_PWR_DEEP && s_reg.pwr != accsr_pkg::ACCSR_PWR_DEEP) begin
              s_next.rangeF = `ACCSR_RANGE_RST;
              s_next.bwF    = `ACCSR_BW_RST;
              s_next.sleepF = `ACCSR_SLEEP_RST;
            end
          end
        end
        default: begin
          s_next.rangeF = s_next.rangeF;
        end
      endcase
    end

    if (regRead) begin
      s_next.rdValid = 1'b1;
      unique case (regAddr)
        `ACCSR_ADDR_ORIENT: s_next.rdData = {s_reg.flat, s_reg.orient, s_reg.highSign, s_reg.highAxis};
        `ACCSR_ADDR_FIFOST: s_next.rdData = {s_reg.overrun, s_reg.count};
        `ACCSR_ADDR_RANGE:  s_next.rdData = {4'h0, s_reg.rangeF};
        `ACCSR_ADDR_BW:     s_next.rdData = {3'h0, s_reg.bwF};
        // sleep field sits in bits 4..1, bit 0 is reserved and reads 0
        `ACCSR_ADDR_PWR:    s_next.rdData = {pwrBits(s_reg.pwr), s_reg.sleepF, 1'b0};
        default:            s_next.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg           <= '0;
      s_reg.rangeF    <= `ACCSR_RANGE_RST;
      s_reg.bwF       <= `ACCSR_BW_RST;
      s_reg.sleepF    <= `ACCSR_SLEEP_RST;
      s_reg.pwr       <= accsr_pkg::ACCSR_PWR_NORMAL;
      s_reg.sleepUs   <= `ACCSR_SLEEP_US_MIN;
      s_reg.bwIdx     <= 3'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign regRdData    = s_reg.rdData;
  assign regRdValid   = s_reg.rdValid;
  assign fifoCfgWrite = s_reg.cfgStrobe;
  assign rangeField   = s_reg.rangeF;
  assign cutoffIdx    = s_reg.bwIdx;
  assign sleepPhaseUs = s_reg.sleepUs;
  assign powerMode    = s_reg.pwr;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence highRise;
    s_reg.highAxis == 3'h0 ##1 s_reg.highAxis != 3'h0;
  endsequence

  a_high_needs_trig: assert property (highRise |-> $past(highTrig))
    else $error("high-g flag rose without an enabled trigger");
  a_perm_holds: assert property (latchKind(latchPolicy) == accsr_pkg::ACCSR_LATCH_K_PERM
      && s_reg.flat && !latchClear |=> s_reg.flat)
    else $error("permanently latched flat flag dropped");
  a_flat_unlatched: assert property (latchKind(latchPolicy) == accsr_pkg::ACCSR_LATCH_K_NONE
      |=> s_reg.flat == $past(flatTrig))
    else $error("unlatched flat bit does not follow enabled posture");
  a_orient_track: assert property (!orientBlock |=> s_reg.orient == $past(orientNow))
    else $error("orientation code not tracking");
  a_orient_freeze: assert property (orientBlock ##1 orientBlock |-> $stable(s_reg.orient))
    else $error("orientation code moved while blocked");
  a_high_record: assert property (highTrig |=> s_reg.highAxis == $past(highAxisNow & highEn)
      && s_reg.highSign == $past(highSignNow))
    else $error("high-g cause not recorded");
  a_ovr_set: assert property (ovrSet |=> s_reg.overrun)
    else $error("overrun not flagged on full push");
  a_ovr_sticky: assert property (s_reg.overrun && !cfgWr |=> s_reg.overrun)
    else $error("overrun cleared without config write");
  a_count_bound: assert property (s_reg.count <= `ACCSR_FIFO_DEPTH)
    else $error("fill count beyond depth");
  a_count_clear: assert property (cfgWr && !framePush |=> s_reg.count == 7'h0)
    else $error("fill count not cleared by config write");
  a_range_legal: assert property (legalRange(s_reg.rangeF))
    else $error("reserved range code stored");
  a_cutoff_top: assert property (s_reg.bwF[4] ##1 $stable(s_reg.bwF) |-> cutoffIdx == 3'h7)
    else $error("top cutoff code not 1000 Hz");
  a_cutoff_step: assert property (s_reg.bwF == 5'h0c ##1 s_reg.bwF == 5'h0c |-> cutoffIdx == 3'h4)
    else $error("cutoff 125 Hz step wrong");
  a_pwr_onehot: assert property ($onehot(s_reg.pwr))
    else $error("power mode not one-hot");
  a_sleep_top: assert property (s_reg.sleepF == 4'hf ##1 s_reg.sleepF == 4'hf
      |-> sleepPhaseUs == `ACCSR_SLEEP_US_15)
    else $error("longest sleep phase wrong");
  a_ro_ignored: assert property (regWrite && regAddr == `ACCSR_ADDR_FIFOST && !framePush && !framePop
      && !cfgWr |=> $stable(s_reg.count) && $stable(s_reg.overrun))
    else $error("write to read-only status changed it");

  // read port answers
  a_rd_strobe: assert property (regRead |=> regRdValid)
    else $error("read not answered in the next cycle");

  a_fill_read: assert property (regRead && regAddr == `ACCSR_ADDR_FIFOST
      |=> regRdData == {$past(s_reg.overrun), $past(s_reg.count)})
    else $error("fill status read back wrong");

  a_orient_read: assert property (regRead && regAddr == `ACCSR_ADDR_ORIENT
      |=> regRdData[6:4] == $past(s_reg.orient))
    else $error("orientation code read back wrong");

  // flags and the temporary window
  a_flat_needs_trig: assert property (!s_reg.flat ##1 s_reg.flat |-> $past(flatTrig))
    else $error("flat flag rose without an enabled posture");

  a_temp_expire: assert property (latchKind(latchPolicy) == accsr_pkg::ACCSR_LATCH_K_TEMP
      && s_reg.timer == 23'h0 && !highTrig |=> s_reg.highAxis == 3'h0)
    else $error("temporary high-g flag outlived its window");

  // queue counters
  a_count_step: assert property (framePush && !framePop && !cfgWr
      && s_reg.count < `ACCSR_FIFO_DEPTH |=> s_reg.count == $past(s_reg.count) + 7'h1)
    else $error("fill count missed a push");

  a_drain_zero: assert property (framePop && !framePush && !cfgWr
      && s_reg.count == 7'h1 |=> s_reg.count == 7'h0)
    else $error("fill count not zero after the last frame left");

  a_cfg_clear: assert property (cfgWr && !ovrSet |=> fifoCfgWrite && !s_reg.overrun)
    else $error("queue config write did not strobe and clear overrun");

  // refused configuration writes, deep suspend defaults and short sleep codes
  a_range_refused: assert property (regWrite && regAddr == `ACCSR_ADDR_RANGE
      && !legalRange(regWrData[3:0]) |=> $stable(s_reg.rangeF))
    else $error("reserved range code accepted");

  a_pwr_illegal: assert property (regWrite && regAddr == `ACCSR_ADDR_PWR
      && $countones(regWrData[`ACCSR_SUSP_BIT:`ACCSR_DEEP_BIT]) > 1
      |=> $stable(s_reg.pwr) && $stable(s_reg.sleepF))
    else $error("illegal power bits accepted");

  a_deep_defaults: assert property (s_reg.pwr != accsr_pkg::ACCSR_PWR_DEEP
      ##1 s_reg.pwr == accsr_pkg::ACCSR_PWR_DEEP
      |-> s_reg.rangeF == `ACCSR_RANGE_RST && s_reg.bwF == `ACCSR_BW_RST)
    else $error("deep suspend kept non-default settings");

  a_deep_locked: assert property (s_reg.pwr == accsr_pkg::ACCSR_PWR_DEEP && regWrite
      && regAddr == `ACCSR_ADDR_RANGE |=> $stable(s_reg.rangeF))
    else $error("range written during deep suspend");

  a_sleep_short: assert property (s_reg.sleepF <= 4'h5 ##1 $stable(s_reg.sleepF)
      |-> sleepPhaseUs == `ACCSR_SLEEP_US_MIN)
    else $error("short sleep codes give the wrong phase");

  c_overrun: cover property (ovrSet ##1 s_reg.overrun);
  c_deep_entry: cover property (s_reg.pwr == accsr_pkg::ACCSR_PWR_NORMAL ##1 s_reg.pwr == accsr_pkg::ACCSR_PWR_DEEP);
  c_high_flag: cover property (highTrig ##1 s_reg.highAxis != 3'h0);
  c_orient_block: cover property (orientBlock [*3]);
  c_temp_expire: cover property (s_reg.highAxis != 3'h0 && s_reg.timer == 23'h1 ##2 s_reg.highAxis == 3'h0);
endmodule
`default_nettype wire

//--- sim/accsr_host.sv
// host processor model that drives the register port of the status/config slice
`timescale 1ns/100ps
`default_nettype none
module accsr_host (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic      [7:0] regWrData,
  output logic            regRead,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid
);
  logic [7:0] rangeShadow = 8'h03;
  logic [7:0] bwShadow    = 8'h0f;
  logic [2:0] modeNow     = 3'b000;
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWrData = 8'h00;
    regRead = 1'b0;
  end
  // released lines show the inverse, so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    regAddr = ~a;
    ok = regRdValid;
    d = regRdData;
  endtask
  // range and cutoff writes are remembered so they can be restored later
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h0f && !(d[3:0] inside {4'h3, 4'h5, 4'h8, 4'hc})) return;
    if (a == 8'h0f) rangeShadow = d;
    if (a == 8'h10) bwShadow = d;
    wr(a, d);
  endtask
  // only legal codes; every change of mode passes through normal
  task automatic power(input logic [2:0] m, input logic [3:0] s);
    if (modeNow != 3'b000 && m != 3'b000) wr(8'h11, {3'b000, s, 1'b0});
    wr(8'h11, {m, s, 1'b0});
    if (modeNow == 3'b001 && m != 3'b001) begin
      wr(8'h0f, rangeShadow);
      wr(8'h10, bwShadow);
    end
    modeNow = m;
  endtask
endmodule
`default_nettype wire

//--- sim/test_accsr_regs.sv
// self-checking bench of the status/config register slice
`timescale 1ns/100ps
`default_nettype none
module test_accsr_regs;
  logic                 clk = 1'b0;
  logic                 reset = 1'b1;
  logic [7:0]           regAddr, regWrData, regRdData;
  logic                 regWrite, regRead, regRdValid, fifoCfgWrite;
  logic [3:0]           latchPolicy = 4'h0, rangeField;
  logic                 latchClear = 1'b0, flatEn = 1'b0, flatNow = 1'b0, orientBlock = 1'b0;
  logic [2:0]           orientNow = 3'h0, highEn = 3'h0, highAxisNow = 3'h0, cutoffIdx;
  logic                 highFire = 1'b0, highSignNow = 1'b0, framePush = 1'b0, framePop = 1'b0;
  logic [19:0]          sleepPhaseUs;
  accsr_pkg::accsr_pwr_t powerMode;
  int                   miscompares = 0, cmp_count = 0, cycles = 0;

  accsr_regs #(.TEMP_LATCH_CYCLES(8)) i_accsr_regs (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
    .regRdValid(regRdValid), .latchPolicy(latchPolicy), .latchClear(latchClear), .flatEn(flatEn),
    .flatNow(flatNow), .orientNow(orientNow), .orientBlock(orientBlock), .highEn(highEn),
    .highFire(highFire), .highSignNow(highSignNow), .highAxisNow(highAxisNow), .framePush(framePush),
    .framePop(framePop), .fifoCfgWrite(fifoCfgWrite), .rangeField(rangeField), .cutoffIdx(cutoffIdx),
    .sleepPhaseUs(sleepPhaseUs), .powerMode(powerMode));
  accsr_host i_accsr_host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
    .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid));

  always #20 clk = ~clk;
  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("[FAIL] run length expected below 5000 cycles seen 5000");
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_accsr_host.rd(a, d, ok);
    chk({what, " strobe"}, 20'h1, {19'h0, ok});
    chk(what, {12'h0, exp}, {12'h0, d});
  endtask
  task automatic edge_pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic t_reset();
    chk_rd("span", 8'h0f, 8'h03);
    chk_rd("cutoff", 8'h10, 8'h0f);
    chk_rd("power", 8'h11, 8'h00);
    chk_rd("unmapped", 8'h20, 8'h00);
    chk_rd("fill", 8'h0e, 8'h00);
    chk("cutoffIdx", 20'd7, {17'h0, cutoffIdx});
    chk("sleepUs", 20'd500, sleepPhaseUs);
    chk("mode", 20'h1, {16'h0, powerMode});
  endtask
  task automatic t_range();
    logic [3:0] codes [4] = '{4'h3, 4'h5, 4'h8, 4'hc};
    foreach (codes[i]) begin
      i_accsr_host.cfg(8'h0f, {4'h0, codes[i]});
      chk_rd("span", 8'h0f, {4'h0, codes[i]});
      chk("rangeField", {16'h0, codes[i]}, {16'h0, rangeField});
    end
    i_accsr_host.wr(8'h0f, 8'h07);
    chk("reserved span", 20'hc, {16'h0, rangeField});
  endtask
  task automatic t_cutoff();
    logic [2:0] exp;
    for (int c = 0; c < 32; c++) begin
      i_accsr_host.cfg(8'h10, 8'(c));
      @(negedge clk);
      exp = c[4] ? 3'd7 : (c <= 8 ? 3'd0 : 3'(c - 8));
      chk("cutoffIdx", {17'h0, exp}, {17'h0, cutoffIdx});
    end
  endtask
  task automatic t_sleep();
    int us [16] = '{500, 500, 500, 500, 500, 500, 1000, 2000, 4000, 6000, 10000, 25000, 50000,
                    100000, 500000, 1000000};
    for (int s = 0; s < 16; s++) begin
      i_accsr_host.power(3'b000, 4'(s));
      @(negedge clk);
      chk("sleepUs", 20'(us[s]), sleepPhaseUs);
    end
    chk_rd("power", 8'h11, 8'h1e);
  endtask
  task automatic t_power();
    logic [2:0] modes [3] = '{3'b010, 3'b100, 3'b001};
    logic [3:0] hot [3] = '{4'h4, 4'h8, 4'h2};
    i_accsr_host.cfg(8'h0f, 8'h08);
    foreach (modes[i]) begin
      i_accsr_host.power(modes[i], 4'h0);
      chk("mode", {16'h0, hot[i]}, {16'h0, powerMode});
    end
    chk("deep span", 20'h3, {16'h0, rangeField});
    i_accsr_host.wr(8'h0f, 8'h05);
    chk("deep span write", 20'h3, {16'h0, rangeField});
    i_accsr_host.power(3'b000, 4'h0);
    chk("span restored", 20'h8, {16'h0, rangeField});
    i_accsr_host.wr(8'h11, 8'hc0);
    chk("illegal mode", 20'h1, {16'h0, powerMode});
    chk_rd("power", 8'h11, 8'h00);
  endtask
  task automatic t_orient();
    latchPolicy = 4'h7;
    for (int o = 0; o < 8; o++) begin
      @(negedge clk);
      orientNow = 3'(o);
      chk_rd("orient", 8'h0c, {1'b0, 3'(o), 4'h0});
    end
    orientBlock = 1'b1;
    orientNow = 3'h2;
    chk_rd("orient frozen", 8'h0c, 8'h70);
    orientBlock = 1'b0;
    chk_rd("orient free", 8'h0c, 8'h20);
    orientNow = 3'h0;
  endtask
  task automatic t_flat_high();
    latchPolicy = 4'h0;
    flatNow = 1'b1;
    chk_rd("flat off", 8'h0c, 8'h00);
    flatEn = 1'b1;
    chk_rd("flat on", 8'h0c, 8'h80);
    flatNow = 1'b0;
    chk_rd("flat gone", 8'h0c, 8'h00);
    latchPolicy = 4'h7;
    highAxisNow = 3'b001;
    highSignNow = 1'b1;
    edge_pulse(highFire);
    chk_rd("high off", 8'h0c, 8'h00);
    highEn = 3'b111;
    edge_pulse(highFire);
    repeat (20) @(negedge clk);
    chk_rd("high held", 8'h0c, 8'h09);
    edge_pulse(latchClear);
    chk_rd("high cleared", 8'h0c, 8'h00);
    latchPolicy = 4'h1;
    highEn = 3'b101;
    highAxisNow = 3'b110;
    highSignNow = 1'b0;
    edge_pulse(highFire);
    repeat (3) @(negedge clk);
    chk_rd("high temp", 8'h0c, 8'h04);
    repeat (10) @(negedge clk);
    chk_rd("high expired", 8'h0c, 8'h00);
  endtask
  task automatic t_queue();
    @(negedge clk);
    framePush = 1'b1;
    repeat (32) @(negedge clk);
    framePush = 1'b0;
    chk_rd("fill", 8'h0e, 8'h20);
    edge_pulse(framePush);
    chk_rd("overrun", 8'h0e, 8'ha0);
    i_accsr_host.wr(8'h0e, 8'h00);
    i_accsr_host.wr(8'h0c, 8'hff);
    chk_rd("fill kept", 8'h0e, 8'ha0);
    chk_rd("status kept", 8'h0c, 8'h00);
    edge_pulse(framePop);
    chk_rd("fill pop", 8'h0e, 8'h9f);
    i_accsr_host.wr(8'h3e, 8'h00);
    chk("cfg strobe", 20'h1, {19'h0, fifoCfgWrite});
    @(negedge clk);
    chk("cfg strobe end", 20'h0, {19'h0, fifoCfgWrite});
    chk_rd("fill cleared", 8'h0e, 8'h00);
    framePush = 1'b1;
    repeat (3) @(negedge clk);
    framePush = 1'b0;
    framePop = 1'b1;
    repeat (3) @(negedge clk);
    framePop = 1'b0;
    chk_rd("fill drained", 8'h0e, 8'h00);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_range();
    t_cutoff();
    t_sleep();
    t_power();
    t_orient();
    t_flat_high();
    t_queue();
    // a second reset in mid-run must bring back every default
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
